/* sbt_smbus_target.v */
// smbus target with indexed block read/write and configuration registers
`include "sbt_consts.vh"

// Contract
// RULE1: start plus matching write address is acknowledged.
// RULE2: index byte N is acknowledged and loads the transfer pointer.
// RULE3: block write count byte X is acknowledged.
// RULE4: X data bytes written to N..N+X-1, each acknowledged.
// RULE5: host ends a block write with stop.
// RULE6: read: write address, index, restart, read address all acknowledged.
// RULE7: first byte returned after read address is the byte count.
// RULE8: then register contents from index N onward.
// RULE9: host acknowledges every returned byte except the last.
// RULE10: host ends read with not-acknowledge then stop.
// RULE11: target address chosen by a latched strap level.
// RULE12: register 0 bits 2 and 1 run outputs 1 and 0.
// RULE13: register 1 bits 7:6 read latched spread strap as 00/01/11.
// RULE14: register 1 bit 5 selects strap or software spread, resets 0.
// RULE15: software spread 00 off, 01 -0.25%, 10 reserved, 11 -0.5%.
// RULE16: software spread field only acts when bit 5 is set.
// RULE17: register 2 bits 2/1 pick edge rate per output, default 1.
// RULE18: register index 4 reads all ones.
// RULE19: reserved and read-only bits ignore writes; reserved read 1.
module sbt_smbus_target (
    input  wire       core_clk,
    input  wire       reset_n,
    input  wire       smbClkIn,
    input  wire       smbDataIn,
    output reg        smbDataOut,
    output reg        smbDataOe_n,
    input  wire       targetAddressStrap,
    input  wire [1:0] spreadStrapLevel,
    output reg        diffOut1Run,
    output reg        diffOut0Run,
    output reg        diffOut1EdgeRateSel,
    output reg        diffOut0EdgeRateSel,
    output reg  [1:0] spreadAmount,
    output reg  [1:0] diffAmplitudeSel
);
    localparam ST_IDLE  = 6'b000001;
    localparam ST_ADDR  = 6'b000010;
    localparam ST_INDEX = 6'b000100;
    localparam ST_COUNT = 6'b001000;
    localparam ST_WRITE = 6'b010000;
    localparam ST_READ  = 6'b100000;

    wire [`SBT_SYNC_W-1:0] syncBus;
    wire                   sclS;
    wire                   sdaS;
    wire                   addrStrapS;
    wire [1:0]             spreadStrapS;

    sbt_sync2 #(
        .WIDTH   (`SBT_SYNC_W)
    ) uSync (
        .clk     (core_clk),
        .rstN    (reset_n),
        .asyncIn ({spreadStrapLevel, targetAddressStrap,
                   ~smbDataIn, ~smbClkIn}),
        .syncOut (syncBus)
    );
    // bus lines pass inverted so the cleared flops read as an idle high bus
    assign sclS         = ~syncBus[0];
    assign sdaS         = ~syncBus[1];
    assign addrStrapS   = syncBus[2];
    assign spreadStrapS = syncBus[4:3];

    reg       sclPrev_q;
    reg       sdaPrev_q;
    reg [5:0] state_q;
    reg [3:0] bitCnt_q;
    reg [7:0] shift_q;
    reg [7:0] ptr_q;
    reg       ackSlot_q;
    reg       devAck_q;
    reg       readPending_q;
    reg       swSel_q;
    reg [1:0] swAmt_q;
    reg [1:0] strapSpread_q;
    reg       addrStrap_q;
    reg       strapTaken_q;
    reg [1:0] strapWait_q;

    wire sclRise = sclS & ~sclPrev_q;
    wire sclFall = ~sclS & sclPrev_q;
    wire startEv = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
    wire stopEv  = sclS & sclPrev_q & ~sdaPrev_q & sdaS;

    wire [6:0] ownAddr = addrStrap_q ? `SBT_ADDR_STRAP_HI
                                     : `SBT_ADDR_STRAP_LO; // RULE11

    // read view of the register file, reserved bits read as one
    reg  [7:0] readNow;
    wire [7:0] countByte = `SBT_READ_COUNT;

    always @* begin
        readNow = `SBT_RESERVED_BYTE; // RULE18 RULE19
        case (ptr_q)
            `SBT_IDX_OE: begin
                readNow[`SBT_BIT_OUT1] = diffOut1Run;
                readNow[`SBT_BIT_OUT0] = diffOut0Run;
            end
            `SBT_IDX_SPREAD: begin
                readNow[`SBT_BIT_STRAP_HI:`SBT_BIT_STRAP_LO] =
                    strapSpread_q; // RULE13
                readNow[`SBT_BIT_SW_SEL] = swSel_q;
                readNow[`SBT_BIT_AMT_HI:`SBT_BIT_AMT_LO] = swAmt_q;
                readNow[`SBT_BIT_AMP_HI:`SBT_BIT_AMP_LO] =
                    diffAmplitudeSel;
            end
            `SBT_IDX_EDGE: begin
                readNow[`SBT_BIT_OUT1] = diffOut1EdgeRateSel;
                readNow[`SBT_BIT_OUT0] = diffOut0EdgeRateSel;
            end
            default: readNow = `SBT_RESERVED_BYTE;
        endcase
    end

    // straps are caught once, after the synchronisers have settled
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            strapWait_q   <= 2'h0;
            strapTaken_q  <= 1'b0;
            addrStrap_q   <= 1'b0;
            strapSpread_q <= 2'h0;
        end else if (!strapTaken_q) begin
            if (strapWait_q == `SBT_STRAP_WAIT) begin
                strapTaken_q  <= 1'b1;
                addrStrap_q   <= addrStrapS; // RULE11
                strapSpread_q <= spreadStrapS; // RULE13
            end else begin
                strapWait_q <= strapWait_q + 2'h1;
            end
        end
    end

    // effective spread: strap unless software owns it
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            spreadAmount <= `SBT_RST_AMT;
        end else begin
            spreadAmount <= swSel_q ? swAmt_q
                                    : strapSpread_q; // RULE14 RULE15 RULE16
        end
    end

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sclPrev_q           <= 1'b1;
            sdaPrev_q           <= 1'b1;
            state_q             <= ST_IDLE;
            bitCnt_q            <= 4'h0;
            shift_q             <= 8'h00;
            ptr_q               <= 8'h00;
            ackSlot_q           <= 1'b0;
            devAck_q            <= 1'b0;
            readPending_q       <= 1'b0;
            smbDataOut          <= 1'b0;
            smbDataOe_n         <= 1'b1;
            diffOut1Run         <= `SBT_RST_RUN;
            diffOut0Run         <= `SBT_RST_RUN;
            diffOut1EdgeRateSel <= `SBT_RST_EDGE;
            diffOut0EdgeRateSel <= `SBT_RST_EDGE;
            swSel_q             <= `SBT_RST_SW_SEL;
            swAmt_q             <= `SBT_RST_AMT;
            diffAmplitudeSel    <= `SBT_RST_AMP;
        end else begin
            sclPrev_q <= sclS;
            sdaPrev_q <= sdaS;
            if (startEv) begin
                // also covers the repeated start of a block read
                state_q       <= ST_ADDR; // RULE1 RULE6
                bitCnt_q      <= 4'h0;
                ackSlot_q     <= 1'b0;
                readPending_q <= 1'b0;
                smbDataOe_n   <= 1'b1;
            end else if (stopEv) begin
                state_q     <= ST_IDLE; // RULE5 RULE10
                ackSlot_q   <= 1'b0;
                smbDataOe_n <= 1'b1;
            end else if (sclRise && state_q != ST_IDLE) begin
                if (ackSlot_q) begin
                    // host not-acknowledge ends the read
                    if (!devAck_q && sdaS) begin
                        state_q <= ST_IDLE; // RULE9 RULE10
                    end
                end else if (bitCnt_q != `SBT_BITS_PER_BYTE) begin
                    if (state_q == ST_READ) begin
                        shift_q <= {shift_q[6:0], 1'b0};
                    end else begin
                        shift_q <= {shift_q[6:0], sdaS};
                    end
                    bitCnt_q <= bitCnt_q + 4'h1;
                end
            end else if (sclFall && state_q != ST_IDLE) begin
                if (ackSlot_q) begin
                    ackSlot_q <= 1'b0;
                    bitCnt_q  <= 4'h0;
                    if (state_q == ST_READ) begin
                        if (readPending_q) begin
                            shift_q       <= countByte; // RULE7
                            smbDataOe_n   <= countByte[`SBT_BITS_PER_BYTE-1];
                            readPending_q <= 1'b0;
                        end else begin
                            shift_q     <= readNow; // RULE8
                            smbDataOe_n <= readNow[`SBT_BITS_PER_BYTE-1];
                            ptr_q       <= ptr_q + 8'h01;
                        end
                    end else begin
                        smbDataOe_n <= 1'b1;
                    end
                end else if (bitCnt_q == `SBT_BITS_PER_BYTE) begin
                    ackSlot_q   <= 1'b1;
                    devAck_q    <= (state_q != ST_READ);
                    smbDataOe_n <= 1'b1;
                    case (state_q)
                        ST_ADDR: begin
                            if (shift_q[7:1] == ownAddr) begin
                                smbDataOe_n <= 1'b0; // RULE1 RULE6
                                if (shift_q[0]) begin
                                    state_q       <= ST_READ;
                                    readPending_q <= 1'b1;
                                end else begin
                                    state_q <= ST_INDEX;
                                end
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end
                        ST_INDEX: begin
                            smbDataOe_n <= 1'b0; // RULE2 RULE6
                            ptr_q       <= shift_q; // RULE2
                            state_q     <= ST_COUNT;
                        end
                        ST_COUNT: begin
                            // count is not needed: stop ends the write
                            smbDataOe_n <= 1'b0; // RULE3
                            state_q     <= ST_WRITE;
                        end
                        ST_WRITE: begin
                            smbDataOe_n <= 1'b0; // RULE4
                            ptr_q       <= ptr_q + 8'h01; // RULE4
                            case (ptr_q)
                                `SBT_IDX_OE: begin
                                    diffOut1Run <=
                                        shift_q[`SBT_BIT_OUT1]; // RULE12
                                    diffOut0Run <=
                                        shift_q[`SBT_BIT_OUT0]; // RULE12
                                end
                                `SBT_IDX_SPREAD: begin
                                    swSel_q <=
                                        shift_q[`SBT_BIT_SW_SEL]; // RULE14
                                    swAmt_q <= shift_q[`SBT_BIT_AMT_HI:
                                                       `SBT_BIT_AMT_LO];
                                    diffAmplitudeSel <=
                                        shift_q[`SBT_BIT_AMP_HI:
                                                `SBT_BIT_AMP_LO];
                                end
                                `SBT_IDX_EDGE: begin
                                    diffOut1EdgeRateSel <=
                                        shift_q[`SBT_BIT_OUT1]; // RULE17
                                    diffOut0EdgeRateSel <=
                                        shift_q[`SBT_BIT_OUT0]; // RULE17
                                end
                                default: ptr_q <= ptr_q + 8'h01; // RULE19
                            endcase
                        end
                        default: state_q <= state_q;
                    endcase
                end else if (state_q == ST_READ) begin
                    smbDataOe_n <= shift_q[7]; // RULE8
                end
            end
        end
    end
endmodule

/* sbt_consts.vh */
// constants for the smbus block configuration target
`ifndef SBT_CONSTS_VH
`define SBT_CONSTS_VH

`define SBT_ADDR_STRAP_LO   7'h68
`define SBT_ADDR_STRAP_HI   7'h6A
`define SBT_READ_COUNT      8'h08
`define SBT_RESERVED_BYTE   8'hFF

`define SBT_IDX_OE          8'h00
`define SBT_IDX_SPREAD      8'h01
`define SBT_IDX_EDGE        8'h02

`define SBT_BIT_OUT1        2
`define SBT_BIT_OUT0        1
`define SBT_BIT_SW_SEL      5
`define SBT_BIT_AMT_HI      4
`define SBT_BIT_AMT_LO      3
`define SBT_BIT_AMP_HI      1
`define SBT_BIT_AMP_LO      0
`define SBT_BIT_STRAP_HI    7
`define SBT_BIT_STRAP_LO    6

`define SBT_RST_RUN         1'b1
`define SBT_RST_EDGE        1'b1
`define SBT_RST_SW_SEL      1'b0
`define SBT_RST_AMT         2'h0
`define SBT_RST_AMP         2'h2

`define SBT_BITS_PER_BYTE   4'h8
`define SBT_STRAP_WAIT      2'h3
`define SBT_SYNC_W          5

`endif

/* sbt_sync2.v */
// two flip-flop synchroniser for asynchronous inputs
module sbt_sync2 #(
    parameter WIDTH = 1
) (
    input  wire             clk,
    input  wire             rstN,
    input  wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] stable_q;

    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            meta_q   <= {WIDTH{1'b0}};
            stable_q <= {WIDTH{1'b0}};
        end else begin
            meta_q   <= asyncIn;
            stable_q <= meta_q;
        end
    end

    assign syncOut = stable_q;
endmodule

/* sbt_smbus_target_assertions.sv */
// port checker for the smbus configuration target
module sbt_smbus_target_assertions (
    input wire       core_clk,
    input wire       reset_n,
    input wire       smbClkIn,
    input wire       smbDataOut,
    input wire       smbDataOe_n,
    input wire [1:0] spreadStrapLevel,
    input wire       diffOut1Run,
    input wire       diffOut0Run,
    input wire       diffOut1EdgeRateSel,
    input wire       diffOut0EdgeRateSel,
    input wire [1:0] spreadAmount,
    input wire [1:0] diffAmplitudeSel
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // a pull that never lets go would hang every device on the bus
    logic [7:0] lowCnt_q;
    logic [5:0] cfg;
    assign cfg = {diffOut1Run, diffOut0Run, diffOut1EdgeRateSel,
                  diffOut0EdgeRateSel, diffAmplitudeSel};
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n)
            lowCnt_q <= 8'h00;
        else
            lowCnt_q <= smbDataOe_n ? 8'h00 : lowCnt_q + 8'h01;
    end
    property p_od; !smbDataOe_n |-> !smbDataOut; endproperty
    a_od: assert property (p_od) else $error("data driven high");
    property p_ackLow;
        $changed(smbDataOe_n) |-> !$past(smbClkIn, 2);
    endproperty
    a_ackLow: assert property (p_ackLow) else $error("data moved");
    property p_fallHold; $fell(smbDataOe_n) |=> !smbDataOe_n [*3]; endproperty
    a_fallHold: assert property (p_fallHold) else $error("short ack");
    property p_riseHold; $rose(smbDataOe_n) |=> smbDataOe_n [*3]; endproperty
    a_riseHold: assert property (p_riseHold) else $error("short bit");
    property p_cfgLow; $changed(cfg) |-> !$past(smbClkIn, 3); endproperty
    a_cfgLow: assert property (p_cfgLow) else $error("cfg moved");
    property p_rst;
        $rose(reset_n) |-> smbDataOe_n && (cfg == 6'h3E);
    endproperty
    a_rst: assert property (p_rst) else $error("bad reset");
    property p_strap;
        $rose(reset_n) |-> ##[5:8] spreadAmount == spreadStrapLevel;
    endproperty
    a_strap: assert property (p_strap) else $error("strap spread");
    property p_bound; lowCnt_q < 8'h50; endproperty
    a_bound: assert property (p_bound) else $error("data stuck low");
endmodule

bind sbt_smbus_target sbt_smbus_target_assertions u_chk (
    .core_clk(core_clk), .reset_n(reset_n), .smbClkIn(smbClkIn),
    .smbDataOut(smbDataOut), .smbDataOe_n(smbDataOe_n),
    .spreadStrapLevel(spreadStrapLevel), .diffOut1Run(diffOut1Run),
    .diffOut0Run(diffOut0Run), .diffOut1EdgeRateSel(diffOut1EdgeRateSel),
    .diffOut0EdgeRateSel(diffOut0EdgeRateSel), .spreadAmount(spreadAmount),
    .diffAmplitudeSel(diffAmplitudeSel));

/* sbt_host_model.sv */
// smbus host controller model making the link clock
module sbt_host_model (
    input  wire logic core_clk,
    input  wire logic sda,
    output logic      smbClk,
    output logic      hostSda
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        smbClk = 1'b1;
        hostSda = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // also serves as repeated start from a low clock
    task automatic start();
        tick(2);
        hostSda <= 1'b1;
        tick(2);
        smbClk <= 1'b1;
        tick(4);
        hostSda <= 1'b0;
        tick(4);
        smbClk <= 1'b0;
    endtask
    task automatic bitIo(input logic b, output logic r);
        tick(2);
        hostSda <= b;
        tick(2);
        smbClk <= 1'b1;
        tick(2);
        r = sda;
        tick(2);
        smbClk <= 1'b0;
    endtask
    task automatic byteIo(input logic [7:0] b, input logic ai,
                          output logic [7:0] r, output logic ao);
        for (int i = 7; i >= 0; i--)
            bitIo(b[i], r[i]);
        bitIo(ai, ao);
    endtask
    task automatic stop();
        tick(2);
        hostSda <= 1'b0;
        tick(2);
        smbClk <= 1'b1;
        tick(4);
        hostSda <= 1'b1;
        tick(4);
    endtask
endmodule

/* smbus_block_config_target_test.sv */
// self-checking bench for the smbus configuration target
`include "sbt_consts.vh"
module smbus_block_config_target_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic       core_clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       strap = 1'b0;
    logic [1:0] sprStrap = 2'h0;
    logic       hostSda, smbClk, dOut, dOe_n, run1, run0, edge1, edge0;
    logic [1:0] sprAmt, amp;
    logic [7:0] m [3];
    logic [7:0] msk [3] = '{8'h06, 8'h3B, 8'h06};
    logic [6:0] adr;
    int         failCount = 0;
    int         comparisons = 0;
    int         cyc = 0;
    wire        sda = hostSda & (dOe_n | dOut);
    sbt_smbus_target u_dut (.core_clk(core_clk), .reset_n(reset_n),
        .smbClkIn(smbClk), .smbDataIn(sda), .smbDataOut(dOut),
        .smbDataOe_n(dOe_n), .targetAddressStrap(strap),
        .spreadStrapLevel(sprStrap), .diffOut1Run(run1), .diffOut0Run(run0),
        .diffOut1EdgeRateSel(edge1), .diffOut0EdgeRateSel(edge0),
        .spreadAmount(sprAmt), .diffAmplitudeSel(amp));
    sbt_host_model u_host (.core_clk(core_clk), .sda(sda), .smbClk(smbClk),
        .hostSda(hostSda));
    initial forever #50 core_clk = ~core_clk;
    task automatic end_sim();
        $display("checks %0d mismatches %0d", comparisons, failCount);
        if (failCount == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            failCount++;
            end_sim();
        end
    end
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            failCount++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask
    function automatic logic [7:0] expRd(input int i);
        case (i)
            0: return 8'hF9 | m[0];
            1: return {sprStrap, 6'h04} | m[1];
            2: return 8'hF9 | m[2];
            default: return 8'hFF;
        endcase
    endfunction
    task automatic chkOut();
        chk({run1, run0, edge1, edge0},
            {m[0][2:1], m[2][2:1]});
        chk({amp, sprAmt},
            {m[1][1:0], m[1][5] ? m[1][4:3] : sprStrap});
    endtask
    task automatic snd(input logic [7:0] b);
        logic [7:0] r;
        logic a;
        u_host.byteIo(b, 1'b1, r, a);
        chk({7'h0, a}, 8'h00);
    endtask
    task automatic wr(input int n, input logic [7:0] d [$]);
        u_host.start();
        snd({adr, 1'b0});
        snd(8'(n));
        snd(8'(d.size()));
        foreach (d[k])
            snd(d[k]);
        u_host.stop();
        foreach (d[k])
            if (n + k < 3)
                m[n + k] = d[k] & msk[n + k];
        chkOut();
    endtask
    task automatic rd(input int n);
        logic [7:0] r;
        logic a;
        u_host.start();
        snd({adr, 1'b0});
        snd(8'(n));
        u_host.start();
        snd({adr, 1'b1});
        u_host.byteIo(8'hFF, 1'b0, r, a);
        chk(r, `SBT_READ_COUNT);
        for (int k = 0; k < `SBT_READ_COUNT; k++) begin
            u_host.byteIo(8'hFF, k == `SBT_READ_COUNT - 1,
                          r, a);
            chk(r, expRd(n + k));
        end
        u_host.stop();
    endtask
    initial begin
        logic [7:0] d [$];
        logic [7:0] r;
        logic a;
        int s;
        int t;
        void'($urandom(32'hac83));
        s = $urandom_range(2);
        t = $urandom_range(1);
        adr = t[0] ? `SBT_ADDR_STRAP_HI : `SBT_ADDR_STRAP_LO;
        m = '{8'h06, 8'h02, 8'h06};
        @(posedge core_clk);
        sprStrap <= {s[1], |s};
        strap    <= t[0];
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (12) @(posedge core_clk);
        chkOut();
        rd(0);
        repeat (4) begin
            d = {};
            repeat (5) d.push_back(8'($urandom));
            wr(0, d);
            rd(0);
        end
        for (int c = 0; c < 4; c++) begin
            d = {};
            d.push_back(8'(8'h20 | (c << 3)));
            wr(1, d);
        end
        rd(2);
        u_host.start();
        u_host.byteIo({adr ^ 7'h02, 1'b0}, 1'b1, r, a);
        chk({7'h0, a}, 8'h01);
        u_host.stop();
        end_sim();
    end
endmodule
